// file: design/gpbr_map.svh
// constants of the general purpose port bank
`ifndef GPBR_MAP_SVH
`define GPBR_MAP_SVH

`define GPBR_NPORT        7
`define GPBR_PORT_W       8
`define GPBR_IDX_W        3
`define GPBR_ANA_PORT     3'h5
`define GPBR_NARROW_PORT  3'h6
`define GPBR_NARROW_W     6
`define GPBR_JTAG_PU_MASK 8'hb0
`define GPBR_CFG_RST      8'h00
`define GPBR_RST_MIN_NS   2500
`define GPBR_CLK_NS       8
`define GPBR_CNT_W        12

`endif

// file: design/gpbr_pkg.sv
// types shared by the port bank files
package gpbr_pkg;

  // per-port configuration: direction (1 = output), output value, pull-up enable
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0] pue;
  } gpbr_cfg_t;

  // peripheral takeover of single pins
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] oe;
    logic [7:0] out;
  } gpbr_alt_t;

  // pad drive: value, output enable (high = driving), pull-up on
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpbr_pad_t;

  typedef enum logic [1:0] {
    GPBR_SEL_DIR = 2'b00,
    GPBR_SEL_OUT = 2'b01,
    GPBR_SEL_PUE = 2'b10,
    GPBR_SEL_PIN = 2'b11
  } gpbr_sel_t;

  typedef enum logic [1:0] {
    GPBR_OP_WRITE  = 2'b00,
    GPBR_OP_SET    = 2'b01,
    GPBR_OP_CLEAR  = 2'b10,
    GPBR_OP_TOGGLE = 2'b11
  } gpbr_op_t;

  typedef struct packed {
    logic [7:0] in;
  } gpbr_pin_st_t;

endpackage : gpbr_pkg

// file: design/gpbr_pin.sv
// one port of the bank: pad drive and input capture
`timescale 1ns/1ps
`default_nettype none
`include "gpbr_map.svh"

module gpbr_pin
  import gpbr_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire gpbr_cfg_t  cfg,
  input  wire gpbr_alt_t  alt,
  input  wire logic       analog_en,
  input  wire logic       hiz,
  input  wire logic [7:0] keep_pu,
  input  wire logic [7:0] pad_in,
  output gpbr_pad_t       pad,
  output logic [7:0]      pin_val
);

  localparam logic [7:0] MASK = 8'((1 << W) - 1);

  gpbr_pin_st_t st_ff;
  gpbr_pin_st_t nxt_st;
  logic [7:0]   dig_oe;
  logic [7:0]   dig_pu;

  // ===========================================
  // pad drive
  always_comb begin
    dig_oe  = (alt.en & alt.oe) | (~alt.en & cfg.dir);
    pad.out = ((alt.en & alt.out) | (~alt.en & cfg.out)) & MASK;
    dig_pu  = cfg.pue & ~cfg.dir & ~alt.en;
    if (analog_en) begin
      dig_oe = 8'h00;
      dig_pu = 8'h00;
    end
    // tri-state while in reset, no clock needed
    pad.oe = hiz ? 8'h00 : (dig_oe & MASK);
    // test pins keep pull-up even in reset
    pad.pu = ((hiz ? 8'h00 : dig_pu) | keep_pu) & MASK;
  end

  // ===========================================
  // input capture
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.in = analog_en ? 8'h00 : (pad_in & MASK);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_val = st_ff.in;

endmodule : gpbr_pin
`default_nettype wire

// file: design/gpbr_top.sv
// bank of bidirectional ports with pull-ups and reset pin filter
`timescale 1ns/1ps
`default_nettype none
`include "gpbr_map.svh"

module gpbr_top
  import gpbr_pkg::*;
#(
  parameter int RST_MIN_NS = `GPBR_RST_MIN_NS,
  parameter int NPORT      = `GPBR_NPORT
) (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      ext_rst_n,
  input  wire logic                      cfg_we,
  input  wire logic [`GPBR_IDX_W-1:0]    cfg_port,
  input  wire gpbr_sel_t                 cfg_sel,
  input  wire gpbr_op_t                  cfg_op,
  input  wire logic [7:0]                cfg_data,
  input  wire logic [`GPBR_IDX_W-1:0]    rd_port,
  input  wire gpbr_sel_t                 rd_sel,
  output logic [7:0]                     rd_data,
  input  wire gpbr_alt_t [NPORT-1:0]     alt,
  input  wire logic [7:0]                analog_en,
  input  wire logic                      jtag_en,
  input  wire logic [NPORT-1:0][7:0]     pad_in,
  output gpbr_pad_t [NPORT-1:0]          pad,
  output logic [NPORT-1:0][7:0]          pin_val,
  output logic                           ext_rst_act
);

  // cycles the reset pin must stay low, rounded up
  localparam int RST_CYC_I = (RST_MIN_NS + `GPBR_CLK_NS - 1) / `GPBR_CLK_NS;
  localparam int RST_CYC   = (RST_CYC_I < 1) ? 1 : RST_CYC_I;
  localparam logic [`GPBR_CNT_W-1:0] RST_LAST = `GPBR_CNT_W'(RST_CYC - 1);

  typedef struct packed {
    gpbr_cfg_t [NPORT-1:0]   cfg;
    logic [`GPBR_CNT_W-1:0]  rst_cnt;
    logic                    ext_rst;
    logic [7:0]              rd;
  } gpbr_state_t;

  gpbr_state_t st_ff;
  gpbr_state_t nxt_st;
  logic        hiz;

  // ===========================================
  // helpers
  function automatic int gpbr_width(input int idx);
    return (idx == int'(`GPBR_NARROW_PORT)) ? `GPBR_NARROW_W : `GPBR_PORT_W;
  endfunction : gpbr_width

  function automatic logic [7:0] gpbr_apply(input gpbr_op_t op, input logic [7:0] old, input logic [7:0] d);
    case (op)
      GPBR_OP_WRITE:  return d;
      GPBR_OP_SET:    return old | d;
      GPBR_OP_CLEAR:  return old & ~d;
      GPBR_OP_TOGGLE: return old ^ d;
      default:        return old;
    endcase
  endfunction : gpbr_apply

  // ===========================================
  // state update
  always_comb begin
    nxt_st = st_ff;
    if (cfg_we && (int'(cfg_port) < NPORT)) begin
      case (cfg_sel)
        GPBR_SEL_DIR: nxt_st.cfg[cfg_port].dir = gpbr_apply(cfg_op, st_ff.cfg[cfg_port].dir, cfg_data);
        GPBR_SEL_OUT: nxt_st.cfg[cfg_port].out = gpbr_apply(cfg_op, st_ff.cfg[cfg_port].out, cfg_data);
        GPBR_SEL_PUE: nxt_st.cfg[cfg_port].pue = gpbr_apply(cfg_op, st_ff.cfg[cfg_port].pue, cfg_data);
        default:      nxt_st.cfg = st_ff.cfg;
      endcase
    end
    if (ext_rst_n) begin
      nxt_st.rst_cnt = '0;
      nxt_st.ext_rst = 1'b0;
    end else if (st_ff.rst_cnt >= RST_LAST) begin
      nxt_st.ext_rst = 1'b1;
    end else begin
      nxt_st.rst_cnt = st_ff.rst_cnt + `GPBR_CNT_W'(1);
    end
    // registered readback
    nxt_st.rd = 8'h00;
    if (int'(rd_port) < NPORT) begin
      case (rd_sel)
        GPBR_SEL_DIR: nxt_st.rd = st_ff.cfg[rd_port].dir;
        GPBR_SEL_OUT: nxt_st.rd = st_ff.cfg[rd_port].out;
        GPBR_SEL_PUE: nxt_st.rd = st_ff.cfg[rd_port].pue;
        GPBR_SEL_PIN: nxt_st.rd = pin_val[rd_port];
        default:      nxt_st.rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NPORT; i++) begin
        st_ff.cfg[i] <= '{dir: `GPBR_CFG_RST, out: `GPBR_CFG_RST, pue: `GPBR_CFG_RST};
      end
      st_ff.rst_cnt <= '0;
      st_ff.ext_rst <= 1'b0;
      st_ff.rd      <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pins float at once on resetn, and on the board reset pin only once the filtered ext_rst is set
  assign hiz         = ~resetn | st_ff.ext_rst;
  assign ext_rst_act = st_ff.ext_rst;
  assign rd_data     = st_ff.rd;

  // ===========================================
  // ports
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      localparam bit ANA = (p == int'(`GPBR_ANA_PORT));
      logic [7:0] keep;
      assign keep = (ANA && jtag_en) ? `GPBR_JTAG_PU_MASK : 8'h00;
      gpbr_pin #(
        .W (gpbr_width(p))
      ) u_pin (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .cfg       (st_ff.cfg[p]),
        .alt       (alt[p]),
        .analog_en (ANA ? (|analog_en) : 1'b0),
        .hiz       (hiz),
        .keep_pu   (keep),
        .pad_in    (pad_in[p]),
        .pad       (pad[p]),
        .pin_val   (pin_val[p])
      );
    end
  endgenerate

endmodule : gpbr_top
`default_nettype wire

// file: tb/gpbr_assertions.sv
// port bank pin checker
`timescale 1ns/1ps
`default_nettype none
module gpbr_chk
  import gpbr_pkg::*;
#(
  parameter int RST_MIN_NS = 2500,
  parameter int NPORT      = 7
) (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  ext_rst_n,
  input wire gpbr_alt_t [NPORT-1:0] alt,
  input wire logic [7:0]            analog_en,
  input wire logic                  jtag_en,
  input wire gpbr_pad_t [NPORT-1:0] pad,
  input wire logic [NPORT-1:0][7:0] pin_val,
  input wire logic                  ext_rst_act
);
  localparam int RC = (RST_MIN_NS + 7) / 8;
  logic any_oe;
  always_comb begin
    any_oe = 1'b0;
    for (int i = 0; i < NPORT; i++) any_oe = any_oe | (|pad[i].oe);
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // ==========
  // pin rules
  rst_hiz_a : assert property (disable iff (1'b0) !resetn |-> !any_oe)
    else $error("pin driven in reset");
  jtag_pu_a : assert property (disable iff (1'b0) jtag_en |-> (pad[5].pu & 8'hb0) == 8'hb0)
    else $error("test pull-up off");
  ext_hiz_a : assert property (ext_rst_act |-> !any_oe)
    else $error("pin driven in board reset");
  ext_filt_a : assert property ($rose(ext_rst_act) |-> $past(ext_rst_n, 2) == 1'b0 && $past(ext_rst_n, RC) == 1'b0)
    else $error("board reset too early");
  ext_free_a : assert property (ext_rst_act && ext_rst_n |=> !ext_rst_act)
    else $error("board reset not released");
  pu_in_a : assert property ((pad[0].pu & pad[0].oe) == 8'h00)
    else $error("pull-up on output");
  alt_take_a : assert property (!ext_rst_act |-> ((pad[3].oe ^ alt[3].oe) & alt[3].en) == 8'h00)
    else $error("takeover ignored");
  narrow_a : assert property (pin_val[6][7:6] == 2'b00 && pad[6].oe[7:6] == 2'b00)
    else $error("narrow port too wide");
  ana_off_a : assert property (|analog_en |-> pad[5].oe == 8'h00 ##1 pin_val[5] == 8'h00)
    else $error("digital on analog port");
endmodule : gpbr_chk
bind gpbr_top gpbr_chk #(.RST_MIN_NS(RST_MIN_NS), .NPORT(NPORT)) gpbr_chk_i (.sys_clk, .resetn, .ext_rst_n,
  .alt, .analog_en, .jtag_en, .pad, .pin_val, .ext_rst_act);
`default_nettype wire

// file: tb/gpbr_board.sv
// board model on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpbr_board
  import gpbr_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire gpbr_pad_t [6:0] pad,
  input  wire logic [6:0][7:0] drv_en,
  input  wire logic [6:0][7:0] drv_val,
  output logic [6:0][7:0]      pad_in
);
  logic [6:0][7:0] last_ff = '0;
  // ==========
  // pin level
  // pulled-up pins read high
  always_comb begin
    for (int i = 0; i < 7; i++) pad_in[i] = (pad[i].oe & pad[i].out) | (~pad[i].oe & drv_en[i] & drv_val[i])
      | (~pad[i].oe & ~drv_en[i] & (pad[i].pu | ~last_ff[i]));
  end
  always_ff @(posedge sys_clk) last_ff <= pad_in;
endmodule : gpbr_board
`default_nettype wire

// file: tb/tb.sv
// port bank bench
`timescale 1ns/1ps
`default_nettype none
module tb
  import gpbr_pkg::*;
;
  logic            sys_clk, resetn, ext_rst_n, cfg_we, jtag_en, ext_rst_act;
  logic [2:0]      cfg_port;
  gpbr_sel_t       cfg_sel, rd_sel;
  gpbr_op_t        cfg_op;
  logic [2:0]      rd_port;
  logic [7:0]      cfg_data, rd_data, analog_en;
  gpbr_alt_t [6:0] alt;
  gpbr_pad_t [6:0] pad;
  logic [6:0][7:0] pad_in, pin_val, drv_en, drv_val;
  int              error_cnt = 0, num_checks = 0, cyc = 0;
  gpbr_top #(.RST_MIN_NS(40)) gpbr_top_i (.sys_clk, .resetn, .ext_rst_n, .cfg_we, .cfg_port, .cfg_sel,
    .cfg_op, .cfg_data, .rd_port, .rd_sel, .rd_data, .alt, .analog_en,
    .jtag_en, .pad_in, .pad, .pin_val, .ext_rst_act);
  gpbr_board gpbr_board_i (.sys_clk, .pad, .drv_en, .drv_val, .pad_in);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] p, input gpbr_sel_t s, input logic [7:0] d);
    @(negedge sys_clk);
    {cfg_we, cfg_port, cfg_data} = {1'b1, p, d};
    cfg_sel = s;
    @(negedge sys_clk);
    cfg_we = 1'b0;
  endtask : wr
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  // ==========
  // scenarios
  task automatic t_hiz();
    for (int k = 0; k < 7; k++) chk("reset pad", 8'h00, pad[k].oe | pad[k].pu);
    wr(3'h0, GPBR_SEL_DIR, 8'hff);
    #1 resetn = 1'b0;
    #1 chk("async oe", 8'h00, pad[0].oe);
    @(negedge sys_clk) resetn = 1'b1;
    $display("hiz done");
  endtask : t_hiz
  task automatic t_ports();
    for (int k = 0; k < 7; k++) begin
      wr(k[2:0], GPBR_SEL_DIR, 8'hff);
      wr(k[2:0], GPBR_SEL_OUT, 8'h5a);
      @(negedge sys_clk);
      chk("port oe", (k == 6) ? 8'h3f : 8'hff, pad[k].oe);
      chk("pin", (k == 6) ? 8'h1a : 8'h5a, pin_val[k]);
    end
    wr(3'h1, GPBR_SEL_DIR, 8'h0f);
    wr(3'h1, GPBR_SEL_PUE, 8'hff);
    chk("pull-up", 8'hf0, pad[1].pu);
    drv_en[1] = 8'h80;
    @(negedge sys_clk);
    chk("pulled pin", 8'h7a, pin_val[1]);
    chk("readback", 8'hff, rd_data);
    analog_en = 8'h01;
    alt[3] = '{en: 8'h0f, oe: 8'h03, out: 8'h01};
    @(negedge sys_clk);
    chk("analog oe", 8'h00, pad[5].oe);
    chk("analog pin", 8'h00, pin_val[5]);
    chk("takeover oe", 8'hf3, pad[3].oe);
    chk("takeover pin", 8'h51, pin_val[3] & 8'hf3);
    $display("ports done");
  endtask : t_ports
  task automatic t_ops();
    rd_port = 3'h0;
    rd_sel  = GPBR_SEL_OUT;
    cfg_op  = GPBR_OP_SET;
    wr(3'h0, GPBR_SEL_OUT, 8'h81);
    @(negedge sys_clk);
    chk("set readback", 8'hdb, rd_data);
    cfg_op = GPBR_OP_CLEAR;
    wr(3'h0, GPBR_SEL_OUT, 8'h0f);
    @(negedge sys_clk);
    chk("clear readback", 8'hd0, rd_data);
    cfg_op = GPBR_OP_TOGGLE;
    wr(3'h0, GPBR_SEL_OUT, 8'hff);
    @(negedge sys_clk);
    chk("toggle readback", 8'h2f, rd_data);
    cfg_op = GPBR_OP_WRITE;
    wr(3'h0, GPBR_SEL_PIN, 8'h00);
    wr(3'h7, GPBR_SEL_OUT, 8'hff);
    @(negedge sys_clk);
    chk("ignored write", 8'h2f, pad[0].out);
    rd_port = 3'h7;
    @(negedge sys_clk);
    chk("absent port", 8'h00, rd_data);
    rd_port = 3'h0;
    rd_sel  = GPBR_SEL_PIN;
    @(negedge sys_clk);
    chk("pin readback", 8'h2f, rd_data);
    $display("ops done");
  endtask : t_ops
  task automatic t_ext();
    ext_rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("short pulse", 8'h00, {7'h0, ext_rst_act});
    ext_rst_n = 1'b1;
    @(negedge sys_clk) ext_rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("long pulse", 8'h01, {7'h0, ext_rst_act} | pad[2].oe);
    ext_rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("kept oe", 8'hff, pad[2].oe);
    jtag_en = 1'b1;
    resetn = 1'b0;
    #1 chk("test pull-ups", 8'hb0, pad[5].pu);
    $display("reset done");
  endtask : t_ext
  initial begin
    {resetn, cfg_we, cfg_port, cfg_data, analog_en, jtag_en} = '0;
    {alt, drv_en, drv_val} = '0;
    ext_rst_n = 1'b1;
    cfg_sel = GPBR_SEL_DIR;
    cfg_op  = GPBR_OP_WRITE;
    rd_port = 3'h1;
    rd_sel  = GPBR_SEL_PUE;
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    t_hiz();
    t_ports();
    t_ops();
    t_ext();
    complete_run();
  end
endmodule : tb
`default_nettype wire
